//--- rtl/cld_defs.vh
`ifndef CLD_DEFS_VH
`define CLD_DEFS_VH

// bus register byte offsets
`define CLD_REG_OSC_DIV 32'h0000_0000
`define CLD_REG_STATUS 32'h0000_0004
`define CLD_REG_IDX_W 3

// clear instruction and blank fill patterns
`define CLD_INS_CLEAR 8'h01
`define CLD_FILL_BLANK 8'h20

// status register field positions
`define CLD_ST_AC_LSB 0
`define CLD_ST_BUSY 7
`define CLD_ST_GLYPH 8
`define CLD_ST_INC 9
`define CLD_ST_SHIFT 10
`define CLD_ST_DISP 11
`define CLD_ST_CURS 12
`define CLD_ST_BLINK 13
`define CLD_ST_WIDTH 14
`define CLD_ST_LINES 15
`define CLD_ST_FONT 16
`define CLD_ST_FSET 17
`define CLD_ST_OFS_LSB 18

// reset values
`define CLD_RST_INC 1'b1
`define CLD_RST_WIDTH 1'b1
`define CLD_RST_AC 7'h00

// clock and oscillator rates
`define CLD_SYS_KHZ 250000
`define CLD_OSC_KHZ 250
`define CLD_OSC_DIV_RST (`CLD_SYS_KHZ / `CLD_OSC_KHZ)

// execution times in ns at the nominal oscillator rate
`define CLD_T_CLEAR_NS 1640000
`define CLD_T_HOME_NS 1600000
`define CLD_T_ENTRY_NS 1640000
`define CLD_T_EXEC_NS 40000

// the same times as oscillator ticks, rounded down (longest times)
`define CLD_TK_CLEAR (`CLD_T_CLEAR_NS * `CLD_OSC_KHZ / 1000000)
`define CLD_TK_HOME (`CLD_T_HOME_NS * `CLD_OSC_KHZ / 1000000)
`define CLD_TK_ENTRY (`CLD_T_ENTRY_NS * `CLD_OSC_KHZ / 1000000)
`define CLD_TK_EXEC (`CLD_T_EXEC_NS * `CLD_OSC_KHZ / 1000000)

`endif

//--- rtl/cld_exec_timer.v
`timescale 1ns/1ps
// busy timer: counts oscillator ticks derived from sys_clk by a divider
module cld_exec_timer (
  input wire sys_clk, // system clock
  input wire srst, // synchronous reset
  input wire start, // start pulse
  input wire [9:0] ticks, // oscillator ticks to run
  input wire [15:0] div, // sys_clk cycles per oscillator tick
  output wire busy // high while running
);
  reg [15:0] pre_q;
  reg [9:0] left_q;
  wire tick;

  // a zero divider would never tick, so it acts as one
  assign tick = (pre_q == 16'h0000) || (pre_q == 16'h0001);
  assign busy = (left_q != 10'h000);

  // prescaler and remaining tick count
  always @(posedge sys_clk) begin
    if (srst) begin
      pre_q <= 16'h0000;
      left_q <= 10'h000;
    end else if (start) begin
      pre_q <= div;
      left_q <= (ticks == 10'h000) ? 10'h001 : ticks;
    end else if (busy) begin
      if (tick) begin
        pre_q <= div;
        left_q <= left_q - 10'h001;
      end else begin
        pre_q <= pre_q - 16'h0001;
      end
    end
  end
endmodule

//--- rtl/cld_decoder.v
`timescale 1ns/1ps
`include "cld_defs.vh"
// Overview of operation
// - clear: blank display memory, address zero
// - home: address zero, undo shift, keep RAM
// - entry mode: increment direction and display shift
// - display, cursor, blink bits; memory kept
// - move cursor or shift display, RAM unchanged
// - function set: width, lines, font
// - glyph address set, later data to glyph RAM
// - display address set, later data to display RAM
// - status read: busy on bit 7, address below
// - busy flag high while executing
// - data write stores into selected RAM
// - data read returns prefetched data register
// - address counter steps after each data access
// - address set copies field into address counter
// - execution times scale with oscillator rate
// - host writes held in registers before execution
// - 4-bit mode: high nibble then low nibble
module cld_decoder (
  input wire sys_clk, // 250 MHz clock
  input wire srst, // synchronous reset, active high
  input wire hsel, // ahb slave select
  input wire [31:0] haddr, // ahb address
  input wire [1:0] htrans, // ahb transfer type
  input wire hwrite, // ahb write
  input wire [2:0] hsize, // ahb size, word only
  input wire [31:0] hwdata, // ahb write data
  input wire hready, // ahb bus ready
  output wire hreadyout, // always ready, no wait states
  output wire hresp, // always okay
  output wire [31:0] hrdata, // ahb read data, registered
  input wire register_select, // high selects data register
  input wire read_not_write, // high reads, low writes
  input wire host_enable, // transfer strobe
  input wire [7:0] host_data_lines_in, // data lines as seen on the pins
  output wire [7:0] host_data_lines_out, // driven read data
  output wire host_data_lines_oe // high while driving the lines
);
  // full-width copies, cut on purpose where they meet narrower registers
  localparam [31:0] TK_EXEC_W = `CLD_TK_EXEC;
  localparam [31:0] TK_ENTRY_W = `CLD_TK_ENTRY;
  localparam [31:0] TK_HOME_W = `CLD_TK_HOME;
  localparam [31:0] TK_CLEAR_W = `CLD_TK_CLEAR;
  localparam [31:0] DIV_RST_W = `CLD_OSC_DIV_RST;
  localparam [31:0] DIV_ADDR_W = `CLD_REG_OSC_DIV;
  reg en_q;
  reg nib_q;
  reg [3:0] hi_q;
  reg xfer_q;
  reg xrs_q;
  reg xrw_q;
  reg [7:0] ins_q;
  reg [7:0] dat_q;
  reg [7:0] out_q;
  reg oe_q;
  reg [6:0] ac_q;
  reg glyph_q;
  reg inc_q;
  reg shen_q;
  reg disp_q;
  reg curs_q;
  reg blink_q;
  reg width_q;
  reg lines_q;
  reg font_q;
  reg fset_q;
  reg [5:0] ofs_q;
  reg clr_q;
  reg [6:0] clr_cnt_q;
  reg fetch_q;
  reg [7:0] dr_q;
  reg start_q;
  reg [9:0] ticks_q;
  reg [15:0] div_q;
  reg wpend_q;
  reg [`CLD_REG_IDX_W-1:0] widx_q;
  reg [31:0] hrdata_q;
  reg [7:0] display_ram [0:127];
  reg [7:0] glyph_ram [0:63];
  wire fall;
  wire [7:0] byte_in;
  wire full;
  wire tbusy;
  wire busy;
  wire [6:0] ac_step;
  wire [7:0] rd_byte;
  wire [31:0] status;
  wire accept;
  wire ins_go;
  wire dat_wr_go;
  wire dat_rd_go;

  // enable falling edge; inputs are synchronous to sys_clk
  assign fall = en_q & ~host_enable;
  // 4-bit mode carries both halves on lines 7..4
  assign byte_in = width_q ? host_data_lines_in : {hi_q, host_data_lines_in[7:4]};
  assign full = width_q | nib_q;

  always @(posedge sys_clk) begin
    if (srst) begin
      en_q <= 1'b0;
    end else begin
      en_q <= host_enable;
    end
  end

  // latch the strobe's qualifiers and data at the falling edge
  always @(posedge sys_clk) begin
    if (srst) begin
      nib_q <= 1'b0;
      hi_q <= 4'h0;
      xfer_q <= 1'b0;
      xrs_q <= 1'b0;
      xrw_q <= 1'b0;
      ins_q <= 8'h00;
      dat_q <= 8'h00;
    end else begin
      xfer_q <= 1'b0;
      if (fall) begin
        if (!width_q) begin
          nib_q <= ~nib_q;
          hi_q <= host_data_lines_in[7:4];
        end
        if (full) begin
          xfer_q <= 1'b1;
          xrs_q <= register_select;
          xrw_q <= read_not_write;
          // writes are held here until executed
          if (!read_not_write && !register_select) begin
            ins_q <= byte_in;
          end
          if (!read_not_write && register_select) begin
            dat_q <= byte_in;
          end
        end
      end
    end
  end

  // busy from the timer or the clear sweep
  assign busy = tbusy | clr_q;
  // instructions and data writes are ignored while busy
  assign ins_go = xfer_q & ~xrs_q & ~xrw_q & ~busy;
  assign dat_wr_go = xfer_q & xrs_q & ~xrw_q & ~busy;
  assign dat_rd_go = xfer_q & xrs_q & xrw_q & ~busy;

  // glyph addresses wrap within six bits
  assign ac_step = glyph_q ? {1'b0, inc_q ? ac_q[5:0] + 6'h01 : ac_q[5:0] - 6'h01} :
    (inc_q ? ac_q + 7'h01 : ac_q - 7'h01);

  // instruction decode and address counter, priority on highest set bit
  always @(posedge sys_clk) begin
    if (srst) begin
      ac_q <= `CLD_RST_AC;
      glyph_q <= 1'b0;
      inc_q <= `CLD_RST_INC;
      shen_q <= 1'b0;
      disp_q <= 1'b0;
      curs_q <= 1'b0;
      blink_q <= 1'b0;
      width_q <= `CLD_RST_WIDTH;
      lines_q <= 1'b0;
      font_q <= 1'b0;
      fset_q <= 1'b0;
      ofs_q <= 6'h00;
      clr_q <= 1'b0;
      fetch_q <= 1'b0;
      start_q <= 1'b0;
      ticks_q <= 10'h000;
    end else begin
      start_q <= 1'b0;
      fetch_q <= 1'b0;
      if (clr_q && clr_cnt_q == 7'h7f) begin
        clr_q <= 1'b0;
      end
      if (ins_go) begin
        start_q <= 1'b1;
        ticks_q <= TK_EXEC_W[9:0];
        if (ins_q[7]) begin
          ac_q <= ins_q[6:0];
          glyph_q <= 1'b0;
          fetch_q <= 1'b1;
        end else if (ins_q[6]) begin
          ac_q <= {1'b0, ins_q[5:0]};
          glyph_q <= 1'b1;
          fetch_q <= 1'b1;
        end else if (ins_q[5]) begin
          width_q <= ins_q[4];
          lines_q <= ins_q[3];
          font_q <= ins_q[2];
          fset_q <= 1'b1;
        end else if (ins_q[4]) begin
          if (!ins_q[3]) begin
            ac_q <= ins_q[2] ? ac_q + 7'h01 : ac_q - 7'h01;
            fetch_q <= 1'b1;
          end else begin
            ofs_q <= ins_q[2] ? ofs_q + 6'h01 : ofs_q - 6'h01;
          end
        end else if (ins_q[3]) begin
          disp_q <= ins_q[2];
          curs_q <= ins_q[1];
          blink_q <= ins_q[0];
        end else if (ins_q[2]) begin
          inc_q <= ins_q[1];
          shen_q <= ins_q[0];
          ticks_q <= TK_ENTRY_W[9:0];
        end else if (ins_q[1]) begin
          ac_q <= `CLD_RST_AC;
          glyph_q <= 1'b0;
          ofs_q <= 6'h00;
          ticks_q <= TK_HOME_W[9:0];
        end else if (ins_q == `CLD_INS_CLEAR) begin
          ac_q <= `CLD_RST_AC;
          glyph_q <= 1'b0;
          ofs_q <= 6'h00;
          clr_q <= 1'b1;
          ticks_q <= TK_CLEAR_W[9:0];
        end else begin
          start_q <= 1'b0;
        end
      end
      if (dat_wr_go) begin
        ac_q <= ac_step;
        start_q <= 1'b1;
        ticks_q <= TK_EXEC_W[9:0];
        // entry shift moves the display opposite to the cursor step
        if (shen_q && !glyph_q) begin
          ofs_q <= inc_q ? ofs_q - 6'h01 : ofs_q + 6'h01;
        end
      end
      if (dat_rd_go) begin
        ac_q <= ac_step;
        fetch_q <= 1'b1;
        start_q <= 1'b1;
        ticks_q <= TK_EXEC_W[9:0];
      end
    end
  end

  // clear sweep walks all display locations, one per cycle
  always @(posedge sys_clk) begin
    if (srst) begin
      clr_cnt_q <= 7'h00;
    end else if (ins_go && ins_q == `CLD_INS_CLEAR) begin
      clr_cnt_q <= 7'h00;
    end else if (clr_q) begin
      clr_cnt_q <= clr_cnt_q + 7'h01;
    end
  end

  // single write port per memory; sweep and writes never overlap
  always @(posedge sys_clk) begin
    if (clr_q) begin
      display_ram[clr_cnt_q] <= `CLD_FILL_BLANK;
    end else if (dat_wr_go && !glyph_q) begin
      display_ram[ac_q] <= dat_q;
    end
    if (dat_wr_go && glyph_q) begin
      glyph_ram[ac_q[5:0]] <= dat_q;
    end
  end

  // data register refilled from the selected memory after address sets, cursor moves and data reads
  always @(posedge sys_clk) begin
    if (srst) begin
      dr_q <= 8'h00;
    end else if (fetch_q) begin
      dr_q <= glyph_q ? glyph_ram[ac_q[5:0]] : display_ram[ac_q];
    end
  end

  cld_exec_timer u_timer (
    .sys_clk(sys_clk),
    .srst(srst),
    .start(start_q),
    .ticks(ticks_q),
    .div(div_q),
    .busy(tbusy)
  );

  // status read is served even while busy
  assign rd_byte = register_select ? dr_q : {busy, ac_q};

  // read data from flops; lines driven one cycle behind a read strobe
  always @(posedge sys_clk) begin
    if (srst) begin
      out_q <= 8'h00;
      oe_q <= 1'b0;
    end else begin
      oe_q <= host_enable & read_not_write;
      if (width_q) begin
        out_q <= rd_byte;
      end else if (!nib_q) begin
        out_q <= {rd_byte[7:4], 4'h0};
      end else begin
        out_q <= {rd_byte[3:0], 4'h0};
      end
    end
  end
  assign host_data_lines_out = out_q;
  assign host_data_lines_oe = oe_q;

  // software view of the block's state
  assign status = {8'h00, ofs_q, fset_q, font_q, lines_q, width_q, blink_q,
    curs_q, disp_q, shen_q, inc_q, glyph_q, busy, ac_q};

  // ahb-lite slave: zero wait states, read data set at address phase
  assign accept = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always @(posedge sys_clk) begin
    if (srst) begin
      wpend_q <= 1'b0;
      widx_q <= {`CLD_REG_IDX_W{1'b0}};
      hrdata_q <= 32'h0000_0000;
    end else begin
      if (hready) begin
        // full decode, so unmapped writes never alias onto the divider
        wpend_q <= accept & hwrite & (haddr == `CLD_REG_OSC_DIV);
        widx_q <= haddr[`CLD_REG_IDX_W-1:0];
      end
      if (accept && !hwrite) begin
        if (haddr == `CLD_REG_OSC_DIV) begin
          hrdata_q <= {16'h0000, div_q};
        end else if (haddr == `CLD_REG_STATUS) begin
          hrdata_q <= status;
        end else begin
          hrdata_q <= 32'h0000_0000;
        end
      end
    end
  end

  // oscillator divider: a slower oscillator stretches every busy time
  always @(posedge sys_clk) begin
    if (srst) begin
      div_q <= DIV_RST_W[15:0];
    end else if (wpend_q && widx_q == DIV_ADDR_W[`CLD_REG_IDX_W-1:0]) begin
      div_q <= hwdata[15:0];
    end
  end
endmodule

//--- tb/cld_checker_properties.sv
`timescale 1ns/1ps
// watches the bus and pin ports of the decoder
module cld_checker (
  input wire sys_clk, // clock
  input wire srst, // sync reset
  input wire hsel, // bus select
  input wire [31:0] haddr, // bus address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // bus write
  input wire hready, // bus ready
  input wire hreadyout, // slave ready
  input wire hresp, // slave response
  input wire [31:0] hrdata, // bus read data
  input wire read_not_write, // pin direction
  input wire host_enable, // pin strobe
  input wire host_data_lines_oe // pin drive enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // a read taken in the address phase
  wire rd_take = hsel && hready && htrans[1] && !hwrite;

  a_ready_high: assert property (hreadyout)
    else $error("slave stretched a transfer");
  a_resp_okay: assert property (!hresp)
    else $error("slave gave an error response");
  a_oe_late: assert property (host_data_lines_oe == $past(host_enable && read_not_write))
    else $error("line drive not one cycle behind strobe");
  a_oe_write_off: assert property ((!read_not_write ##1 !read_not_write) |-> !host_data_lines_oe)
    else $error("lines driven during a write");
  a_oe_idle: assert property (!host_enable [*2] |-> !host_data_lines_oe)
    else $error("lines driven without strobe");
  a_oe_read_on: assert property ((host_enable && read_not_write) [*2] |-> host_data_lines_oe)
    else $error("lines not driven during a read");
  a_rd_hold: assert property (!$past(rd_take) |-> $stable(hrdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (rd_take && haddr >= 32'h0000_0008 |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule

bind cld_decoder cld_checker chk_u (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .read_not_write(read_not_write), .host_enable(host_enable),
  .host_data_lines_oe(host_data_lines_oe));

//--- tb/cld_host_model.sv
`timescale 1ns/1ps
// host side of the strobe bus: a byte, or two nibbles in narrow mode
module cld_host_model (
  input wire sys_clk, // clock
  output reg register_select, // register choice
  output reg read_not_write, // direction
  output reg host_enable, // strobe
  output wire [7:0] host_data_lines_in, // level on the lines
  input wire [7:0] host_data_lines_out, // device read data
  input wire host_data_lines_oe // device drives lines
);
  reg [7:0] drv = 8'h00; // host line value
  reg drv_en = 1'b0; // host drives lines
  reg four_bit = 1'b0; // narrow bus mode
  // released lines show the inverse so a stale value never passes
  assign host_data_lines_in = host_data_lines_oe ? host_data_lines_out : (drv_en ? drv : ~drv);
  initial begin
    register_select = 1'b0;
    read_not_write = 1'b0;
    host_enable = 1'b0;
  end
  // one strobe: hold three cycles, sample, then fall
  task strobe(input logic rs, input logic rw, input logic [7:0] b, output logic [7:0] r);
    begin
      @(posedge sys_clk);
      register_select <= rs;
      read_not_write <= rw;
      drv <= b;
      drv_en <= !rw;
      host_enable <= 1'b1;
      repeat (3) @(posedge sys_clk);
      r = host_data_lines_in;
      host_enable <= 1'b0;
      @(posedge sys_clk);
      drv_en <= 1'b0;
    end
  endtask
  // whole byte transfer in either bus width
  task xfer(input logic rs, input logic rw, input logic [7:0] b, output logic [7:0] r);
    logic [7:0] hi;
    logic [7:0] lo;
    begin
      if (four_bit) begin
        strobe(rs, rw, b, hi);
        strobe(rs, rw, {b[3:0], 4'h0}, lo);
        r = {hi[7:4], lo[7:4]};
      end else begin
        strobe(rs, rw, b, r);
      end
    end
  endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "cld_defs.vh"
// decoder bench: status over the bus, traffic over the strobe pins
module tb_top;
  reg sys_clk = 1'b0;
  reg srst = 1'b1;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0000_0000;
  reg [1:0] htrans = 2'b00;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0000_0000;
  wire hreadyout, hresp, host_enable, register_select, read_not_write, lines_oe;
  wire [31:0] hrdata;
  wire [7:0] lines_in;
  wire [7:0] lines_out;
  integer err_count = 0;
  integer checked = 0;
  reg [31:0] st;
  reg [7:0] rb;
  always #2 sys_clk = ~sys_clk;

  cld_decoder dut_u (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .register_select(register_select),
    .read_not_write(read_not_write), .host_enable(host_enable),
    .host_data_lines_in(lines_in), .host_data_lines_out(lines_out),
    .host_data_lines_oe(lines_oe));
  cld_host_model host_u (.sys_clk(sys_clk), .register_select(register_select),
    .read_not_write(read_not_write), .host_enable(host_enable),
    .host_data_lines_in(lines_in), .host_data_lines_out(lines_out),
    .host_data_lines_oe(lines_oe));

  task print_verdict;
    begin
      if (err_count == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // single word transfer; read data lands in st
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    begin
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      st = hrdata;
    end
  endtask
  // poll the status read until not busy; rb keeps the last status
  task idle;
    begin
      rb = 8'h80;
      while (rb[7] !== 1'b0) host_u.xfer(1'b0, 1'b1, 8'h00, rb);
    end
  endtask
  task ins(input logic [7:0] b);
    begin
      host_u.xfer(1'b0, 1'b0, b, rb);
      idle;
    end
  endtask
  task dw(input logic [7:0] b);
    begin
      host_u.xfer(1'b1, 1'b0, b, rb);
      idle;
    end
  endtask
  task dr(input logic [7:0] exp);
    begin
      host_u.xfer(1'b1, 1'b1, 8'h00, rb);
      chk(rb, exp);
      idle;
    end
  endtask
  task t_reset;
    begin
      ahb(1'b0, `CLD_REG_STATUS, 32'h0000_0000);
      chk(st[14:0], 15'h4200);
      ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
      chk(st, 32'h0000_0000);
      ahb(1'b1, `CLD_REG_OSC_DIV, 32'h0000_0002);
      ahb(1'b1, 32'h0000_0010, 32'h0000_0007);
      ahb(1'b0, `CLD_REG_OSC_DIV, 32'h0000_0000);
      chk(st, 32'h0000_0002);
      ins(8'h38);
      ahb(1'b0, `CLD_REG_STATUS, 32'h0000_0000);
      chk(st[17:14], 4'hb);
    end
  endtask
  task t_ram;
    begin
      ins(8'h85);
      chk(rb, 8'h05);
      dw(8'h41);
      dw(8'h42);
      chk(rb, 8'h07);
      ins(8'h85);
      dr(8'h41);
      dr(8'h42);
      chk(rb, 8'h07);
      ins(8'h43);
      chk(rb, 8'h03);
      dw(8'h1f);
      ins(8'h43);
      dr(8'h1f);
      ahb(1'b0, `CLD_REG_STATUS, 32'h0000_0000);
      chk(st[8], 1'b1);
    end
  endtask
  task t_entry;
    begin
      ins(8'h04);
      ahb(1'b0, `CLD_REG_STATUS, 32'h0000_0000);
      chk(st[10:9], 2'b00);
      ins(8'h88);
      dw(8'h55);
      chk(rb, 8'h07);
      ins(8'h07);
      ahb(1'b0, `CLD_REG_STATUS, 32'h0000_0000);
      chk(st[10:9], 2'b11);
      dw(8'h56);
      chk(rb, 8'h08);
      ahb(1'b0, `CLD_REG_STATUS, 32'h0000_0000);
      chk(st[23:18], 6'h3f);
      ins(8'h1c);
      ahb(1'b0, `CLD_REG_STATUS, 32'h0000_0000);
      chk(st[23:18], 6'h00);
      ins(8'h06);
      ins(8'h0f);
      ahb(1'b0, `CLD_REG_STATUS, 32'h0000_0000);
      chk(st[13:11], 3'b111);
    end
  endtask
  task t_shift;
    begin
      ins(8'h8a);
      ins(8'h14);
      chk(rb, 8'h0b);
      ins(8'h10);
      chk(rb, 8'h0a);
      ins(8'h1c);
      ahb(1'b0, `CLD_REG_STATUS, 32'h0000_0000);
      chk(st[23:18], 6'h01);
      // address counter is 0x0a here and the display offset is 1
      ins(8'h02);
      ins(8'h02);
      chk(rb, 8'h00);
      ahb(1'b0, `CLD_REG_STATUS, 32'h0000_0000);
      chk(st[23:18], 6'h00);
    end
  endtask
  task t_busy;
    begin
      host_u.xfer(1'b0, 1'b0, 8'h01, rb);
      host_u.xfer(1'b0, 1'b1, 8'h00, rb);
      chk(rb[7], 1'b1);
      idle;
      chk(rb, 8'h00);
      ins(8'h80);
      dr(8'h20);
      host_u.xfer(1'b0, 1'b0, 8'h90, rb);
      host_u.xfer(1'b0, 1'b0, 8'ha0, rb);
      idle;
      chk(rb, 8'h10);
    end
  endtask
  task t_nibble;
    begin
      host_u.xfer(1'b0, 1'b0, 8'h28, rb);
      host_u.four_bit = 1'b1;
      idle;
      ins(8'h8a);
      chk(rb, 8'h0a);
      dw(8'h66);
      ins(8'h8a);
      dr(8'h66);
      ahb(1'b0, `CLD_REG_STATUS, 32'h0000_0000);
      chk(st[16:14], 3'b010);
    end
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset;
    t_ram;
    t_entry;
    t_shift;
    t_busy;
    t_nibble;
    print_verdict;
  end
  // watchdog well past the expected few thousand cycles
  initial begin
    #200000;
    err_count = err_count + 1;
    print_verdict;
  end
endmodule
